// *** hdl/brw_pkg.sv ***
package brw_pkg;
	localparam int DW         = 16;
	localparam int AW         = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int PIN_W      = AW + 5;

	// read setup word layout
	localparam logic [15:0] SETUP_RST   = 16'hfd4f;
	localparam logic [15:0] SETUP_WMASK = 16'hfd4f;
	localparam int MODE_BIT  = 15;
	localparam int LAT_HI    = 14;
	localparam int LAT_LO    = 11;
	localparam int POL_BIT   = 10;
	localparam int EARLY_BIT = 8;
	localparam int ORDER_BIT = 7;
	localparam int EDGE_BIT  = 6;
	localparam int WRAP_BIT  = 3;
	localparam int SIZE_HI   = 2;

	// burst size codes
	localparam logic [2:0] SIZE_4    = 3'h1;
	localparam logic [2:0] SIZE_8    = 3'h2;
	localparam logic [2:0] SIZE_16   = 3'h3;
	localparam logic [2:0] SIZE_CONT = 3'h7;

	localparam logic [3:0] MASK_4    = 4'h3;
	localparam logic [3:0] MASK_8    = 4'h7;
	localparam logic [3:0] MASK_16   = 4'hf;
	localparam logic [3:0] ROW_LAST  = 4'hf;
	localparam logic [3:0] ROW_FIRST = 4'h0;
	localparam logic [3:0] CNT_ONE   = 4'h1;
	localparam logic [3:0] LAT_MIN   = 4'h5;
	localparam logic [4:0] WORDS_4   = 5'h04;
	localparam logic [4:0] WORDS_8   = 5'h08;
	localparam logic [4:0] WORDS_16  = 5'h10;

	typedef struct packed {
		logic       sync_mode;
		logic [3:0] delay_code;
		logic       pol;
		logic       early;
		logic       edge_rise;
		logic       wrap_dis;
		logic [2:0] size;
	} brw_cfg_s;

	typedef struct packed {
		logic          clk;
		logic          cs_n;
		logic          oe_n;
		logic          we_n;
		logic          adv_n;
		logic [AW-1:0] addr;
	} brw_pins_s;

	typedef enum {ST_IDLE, ST_LAT, ST_DATA, ST_STALL, ST_DONE} brw_state_e;
endpackage

// *** hdl/brw_sync2.sv ***
module brw_sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] q_sync
);
	logic [W-1:0] meta_reg;

	// two flops per bit, first read only by second
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
				begin
					meta_reg[i] <= 1'b1;
					q_sync[i]   <= 1'b1;
				end
				else
				begin
					meta_reg[i] <= d_async[i];
					q_sync[i]   <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule

// *** hdl/brw_fifo.sv ***
module brw_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [PW:0]      count_reg;
	logic             push;
	logic             pop;

	// honest full and empty from the occupancy count
	assign in_ready  = (count_reg != (PW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;

	// storage write
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// pointers and count
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else if (flush)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	property p_no_overfill;
		@(posedge sys_clk) disable iff (rst) count_reg <= (PW+1)'(DEPTH);
	endproperty
	a_no_overfill: assert property (p_no_overfill)
		else $error("fifo count beyond depth");
	property p_empty_flag;
		@(posedge sys_clk) disable iff (rst) !out_valid |-> (count_reg == '0);
	endproperty
	a_empty_flag: assert property (p_empty_flag)
		else $error("fifo empty flag wrong");
endmodule

// *** hdl/brw_top.sv ***
// Functional notes
// - setup mode bit 1 gives asynchronous page reads, 0 gives synchronous bursts.
// - first data word driven after delay code bus clock edges from address capture.
// - row end stalls only when start word offset within 16-word row nonzero.
// - codes 5..15: 16 words then 0 to code-1 stalls; codes 1..4 unsupported.
// - wait asserted high when polarity bit is 1, low when 0.
// - wait changes only on bus clock edges while chip and output enabled.
// - in sync mode with early bit 0, wait stays asserted until data valid on the bus.
// - nonarray sync reads deassert wait on valid data; row stall first access only.
// - asynchronous reads hold wait at its deasserted level.
// - wait floats unless chip select and output enable both low.
// - wait floats during all write cycles.
// - early bit 1 deasserts wait one cycle ahead of data, 0 with it.
// - only linear burst order; order bit always reads linear.
// - delay code in setup bits 14:11, codes 0..2 reserved, default 15.
// - reset returns read setup to asynchronous mode.
// - wrap disable 1 crosses size blocks linearly, 0 wraps inside block.
module brw_top (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic                    cfg_load,
	input  wire logic [15:0]             cfg_word,
	output logic      [15:0]             read_setup_word,
	output logic                         burst_order_bit,
	input  wire logic                    pin_clk,
	input  wire logic                    addr_valid_n,
	input  wire logic                    pin_cs_n,
	input  wire logic                    pin_oe_n,
	input  wire logic                    pin_we_n,
	input  wire logic [brw_pkg::AW-1:0]  pin_addr,
	output logic      [brw_pkg::DW-1:0]  dq_out,
	output logic                         dq_oe,
	output logic                         wait_out,
	output logic                         wait_oe,
	output logic      [brw_pkg::AW-1:0]  arr_addr,
	input  wire logic [brw_pkg::DW-1:0]  arr_word,
	input  wire logic                    arr_valid,
	output logic                         arr_ready,
	output logic                         burst_active
);
	brw_pkg::brw_pins_s  pins_raw;
	brw_pkg::brw_pins_s  pins;
	brw_pkg::brw_cfg_s   cfg;
	brw_pkg::brw_state_e state_reg;
	brw_pkg::brw_state_e state_next;
	logic [15:0]         setup_reg;
	logic                clk_d_reg;
	logic                bus_edge;
	logic                active;
	logic [3:0]          cnt_reg;
	logic [3:0]          cnt_next;
	logic [3:0]          stall_n_reg;
	logic                stall_armed_reg;
	logic [4:0]          left_reg;
	logic [brw_pkg::AW-1:0] cur_reg;
	logic [brw_pkg::AW-1:0] fetch_reg;
	logic                emit;
	logic                enter_stall;
	logic                capture;
	logic                valid_reg;
	logic                wait_assert_reg;
	logic                pred_valid;
	logic                stall_ahead;
	logic                flush;
	logic [brw_pkg::DW-1:0] fifo_data;
	logic                fifo_valid;
	logic                fifo_pop;

	// pin inputs cross into sys_clk
	assign pins_raw = '{clk: pin_clk, cs_n: pin_cs_n, oe_n: pin_oe_n, we_n: pin_we_n,
		adv_n: addr_valid_n, addr: pin_addr};
	brw_sync2 #(.W(brw_pkg::PIN_W)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.d_async (pins_raw),
		.q_sync  (pins)
	);

	// read setup word, defaults to async on reset
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			setup_reg <= brw_pkg::SETUP_RST;
		else if (cfg_load)
			setup_reg <= cfg_word & brw_pkg::SETUP_WMASK;
	end

	assign cfg.sync_mode  = !setup_reg[brw_pkg::MODE_BIT];
	assign cfg.delay_code = setup_reg[brw_pkg::LAT_HI:brw_pkg::LAT_LO];
	assign cfg.pol        = setup_reg[brw_pkg::POL_BIT];
	assign cfg.early      = setup_reg[brw_pkg::EARLY_BIT];
	assign cfg.edge_rise  = setup_reg[brw_pkg::EDGE_BIT];
	assign cfg.wrap_dis   = setup_reg[brw_pkg::WRAP_BIT];
	assign cfg.size       = setup_reg[brw_pkg::SIZE_HI:0];
	assign read_setup_word = setup_reg;
	assign burst_order_bit = setup_reg[brw_pkg::ORDER_BIT];

	// bus clock edge detect on the synchronised pin
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			clk_d_reg <= 1'b1; // same level as the synchroniser reset, no false edge
		else
			clk_d_reg <= pins.clk;
	end
	assign bus_edge = cfg.edge_rise ? (pins.clk && !clk_d_reg) : (!pins.clk && clk_d_reg);
	assign active   = !pins.cs_n && !pins.oe_n && pins.we_n;

	// next linear address, wrapping inside the size block when enabled
	function automatic logic [brw_pkg::AW-1:0] next_addr(
		input logic [brw_pkg::AW-1:0] a,
		input brw_pkg::brw_cfg_s c
	);
		logic [3:0] m;
		logic [brw_pkg::AW-1:0] inc;
		m = '0;
		inc = a + 1'b1;
		case (c.size)
			brw_pkg::SIZE_4:  m = brw_pkg::MASK_4;
			brw_pkg::SIZE_8:  m = brw_pkg::MASK_8;
			brw_pkg::SIZE_16: m = brw_pkg::MASK_16;
			default:          m = '0;
		endcase
		if (c.wrap_dis || m == '0)
			return inc;
		return {a[brw_pkg::AW-1:4], (a[3:0] & ~m) | (inc[3:0] & m)};
	endfunction

	// words in a finite burst, zero for continuous
	function automatic logic [4:0] burst_words(input logic [2:0] s);
		case (s)
			brw_pkg::SIZE_4:  return brw_pkg::WORDS_4;
			brw_pkg::SIZE_8:  return brw_pkg::WORDS_8;
			brw_pkg::SIZE_16: return brw_pkg::WORDS_16;
			default:          return '0;
		endcase
	endfunction

	assign capture = bus_edge && cfg.sync_mode && !pins.adv_n && !pins.cs_n;
	assign enter_stall = stall_armed_reg && (cur_reg[3:0] == brw_pkg::ROW_LAST)
		&& (stall_n_reg != '0);

	// burst sequencing
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		emit       = 1'b0;
		case (state_reg)
			brw_pkg::ST_IDLE:
				state_next = brw_pkg::ST_IDLE;
			brw_pkg::ST_LAT:
			begin
				if (cnt_reg == brw_pkg::CNT_ONE)
				begin
					emit = fifo_valid;
					if (fifo_valid)
						state_next = brw_pkg::ST_DATA;
				end
				else
					cnt_next = cnt_reg - 1'b1;
			end
			brw_pkg::ST_DATA:
			begin
				if (enter_stall)
				begin
					state_next = brw_pkg::ST_STALL;
					cnt_next   = stall_n_reg;
				end
				else
				begin
					emit = fifo_valid;
					if (fifo_valid && left_reg == 5'h01)
						state_next = brw_pkg::ST_DONE;
				end
			end
			brw_pkg::ST_STALL:
			begin
				if (cnt_reg == brw_pkg::CNT_ONE)
				begin
					emit = fifo_valid;
					if (fifo_valid)
						state_next = (left_reg == 5'h01) ? brw_pkg::ST_DONE : brw_pkg::ST_DATA;
				end
				else
					cnt_next = cnt_reg - 1'b1;
			end
			brw_pkg::ST_DONE:
				state_next = brw_pkg::ST_DONE;
			default:
				state_next = brw_pkg::ST_IDLE;
		endcase
	end

	// data expected at the following edge, for early wait release
	// a stall follows the next word only if stalls are due at all
	assign stall_ahead = stall_armed_reg && (stall_n_reg != '0)
		&& ((state_reg == brw_pkg::ST_LAT && cur_reg[3:0] == brw_pkg::ROW_LAST)
		|| (state_reg == brw_pkg::ST_DATA && cur_reg[3:0] == brw_pkg::MASK_16 - 1'b1));
	assign pred_valid = ((state_next == brw_pkg::ST_LAT || state_next == brw_pkg::ST_STALL)
		&& cnt_next == brw_pkg::CNT_ONE) || (state_next == brw_pkg::ST_DATA && !stall_ahead);

	// state, counters and captured address on bus edges
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg       <= brw_pkg::ST_IDLE;
			cnt_reg         <= '0;
			cur_reg         <= '0;
			left_reg        <= '0;
			stall_n_reg     <= '0;
			stall_armed_reg <= 1'b0;
		end
		else if (pins.cs_n || !cfg.sync_mode)
			state_reg <= brw_pkg::ST_IDLE;
		else if (capture)
		begin
			state_reg <= brw_pkg::ST_LAT;
			cnt_reg   <= cfg.delay_code;
			cur_reg   <= pins.addr;
			left_reg  <= burst_words(cfg.size);
			stall_armed_reg <= (pins.addr[3:0] != brw_pkg::ROW_FIRST)
				&& (cfg.wrap_dis || cfg.size == brw_pkg::SIZE_CONT);
			stall_n_reg <= (pins.addr[1:0] == 2'h0) ? 4'h0
				: cfg.delay_code - 4'h4 + {2'h0, pins.addr[1:0]};
		end
		else if (bus_edge)
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (state_reg == brw_pkg::ST_STALL && state_next == brw_pkg::ST_DATA)
				stall_armed_reg <= 1'b0;
			if (emit && state_reg != brw_pkg::ST_LAT)
				cur_reg <= next_addr(cur_reg, cfg);
			if (emit && left_reg != '0)
				left_reg <= left_reg - 1'b1;
		end
	end

	// output data and wait level, updated on bus edges in sync mode, every clock in async mode
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			dq_out          <= '0;
			valid_reg       <= 1'b0;
			wait_assert_reg <= 1'b0;
		end
		else if (!cfg.sync_mode)
		begin
			valid_reg       <= 1'b0;
			wait_assert_reg <= 1'b0;
			if (fifo_valid)
				dq_out <= fifo_data;
		end
		else if (bus_edge && active)
		begin
			if (emit)
				dq_out <= fifo_data;
			valid_reg <= emit || (valid_reg && state_next == brw_pkg::ST_DONE);
			if (state_next == brw_pkg::ST_IDLE || state_next == brw_pkg::ST_DONE)
				wait_assert_reg <= 1'b0;
			else if (cfg.early)
				wait_assert_reg <= !pred_valid;
			else
				wait_assert_reg <= !emit;
		end
	end

	assign wait_out = wait_assert_reg ? cfg.pol : !cfg.pol;
	assign wait_oe  = active;
	assign dq_oe    = active;
	assign burst_active = (state_reg != brw_pkg::ST_IDLE);

	// array prefetch into the fifo, restarted by each capture
	assign flush    = capture;
	assign fifo_pop = (bus_edge && emit) || (!cfg.sync_mode && fifo_valid && pins.cs_n);
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			fetch_reg <= '0;
		else if (capture)
			fetch_reg <= pins.addr;
		else if (arr_valid && arr_ready)
			fetch_reg <= next_addr(fetch_reg, cfg);
	end
	assign arr_addr = fetch_reg;

	brw_fifo #(.WIDTH(brw_pkg::DW), .DEPTH(brw_pkg::FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.flush     (flush),
		.in_data   (arr_word),
		.in_valid  (arr_valid),
		.in_ready  (arr_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// helper: bus edges since capture
	logic [4:0] edge_cnt_h;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			edge_cnt_h <= '0;
		else if (capture)
			edge_cnt_h <= '0;
		else if (bus_edge && edge_cnt_h != 5'h1f)
			edge_cnt_h <= edge_cnt_h + 1'b1;
	end

	property p_first_lat;
		@(posedge sys_clk) disable iff (rst)
		(state_reg == brw_pkg::ST_LAT && state_next == brw_pkg::ST_DATA && bus_edge)
		|-> (edge_cnt_h + 1'b1 >= {1'b0, cfg.delay_code});
	endproperty
	a_first_lat: assert property (p_first_lat) else $error("first word early");
	property p_async_wait;
		@(posedge sys_clk) disable iff (rst)
		!cfg.sync_mode ##1 !cfg.sync_mode |-> (wait_out == !cfg.pol);
	endproperty
	a_async_wait: assert property (p_async_wait) else $error("async wait asserted");
	property p_float;
		@(posedge sys_clk) disable iff (rst) (pins.cs_n || pins.oe_n) |-> !wait_oe;
	endproperty
	a_float: assert property (p_float) else $error("wait driven while idle");
	property p_write;
		@(posedge sys_clk) disable iff (rst) !pins.we_n |-> !wait_oe && !dq_oe;
	endproperty
	a_write: assert property (p_write) else $error("wait driven in write");
	property p_edge_only;
		@(posedge sys_clk) disable iff (rst)
		cfg.sync_mode && $stable(cfg.sync_mode) && !bus_edge |=> $stable(wait_assert_reg);
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("wait moved off edge");
	property p_late_wait;
		@(posedge sys_clk) disable iff (rst)
		cfg.sync_mode && !cfg.early && bus_edge && active && emit
		|=> !wait_assert_reg && valid_reg;
	endproperty
	a_late_wait: assert property (p_late_wait) else $error("wait not with data");
	property p_stall_len;
		@(posedge sys_clk) disable iff (rst)
		state_reg == brw_pkg::ST_STALL |-> cnt_reg <= cfg.delay_code - 1'b1;
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall too long");
	property p_reset_async;
		@(posedge sys_clk) disable iff (rst)
		$fell(rst) |-> !cfg.sync_mode && cfg.delay_code == 4'hf;
	endproperty
	a_reset_async: assert property (p_reset_async) else $error("setup not async");
	property p_linear;
		@(posedge sys_clk) disable iff (rst) !burst_order_bit;
	endproperty
	a_linear: assert property (p_linear) else $error("order not linear");

	c_burst: cover property (@(posedge sys_clk) disable iff (rst)
		state_reg == brw_pkg::ST_DATA ##[1:200] state_reg == brw_pkg::ST_DONE);
	c_stall: cover property (@(posedge sys_clk) disable iff (rst)
		state_reg == brw_pkg::ST_STALL);
	c_async: cover property (@(posedge sys_clk) disable iff (rst)
		!cfg.sync_mode && active);
endmodule

// *** test/brw_host_model.sv ***
// bus controller: drives the flash pins, records wait and data per bus edge
module brw_host_model (
	input  wire logic                   sys_clk,
	input  wire logic [brw_pkg::DW-1:0] dq_out,
	input  wire logic                   wait_out,
	output logic                        pin_clk,
	output logic                        addr_valid_n,
	output logic                        pin_cs_n,
	output logic                        pin_oe_n,
	output logic                        pin_we_n,
	output logic      [brw_pkg::AW-1:0] pin_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        wt [0:63];
	logic [15:0] dq [0:63];
	int          glitch;

	// idle levels, bus clock parked low
	initial
	begin
		pin_clk = 1'b0;
		addr_valid_n = 1'b1;
		{pin_cs_n, pin_oe_n, pin_we_n} = 3'h7;
		pin_addr = 16'h0000;
		glitch = 0;
	end

	// set the strobes and let the synchronisers settle
	task automatic ctl(input logic cs, input logic oe, input logic we);
		@(negedge sys_clk);
		{pin_cs_n, pin_oe_n, pin_we_n} = {cs, oe, we};
		repeat (6) @(negedge sys_clk);
	endtask

	// one read burst of ne edges after the capture edge
	// fe set: device works on falling bus clock edges
	task automatic burst(input logic [15:0] a, input int ne, input logic fe);
		logic wm;
		@(negedge sys_clk);
		{pin_cs_n, pin_oe_n, pin_we_n} = 3'h1;
		addr_valid_n = 1'b0;
		pin_addr = a;
		repeat (6) @(negedge sys_clk);
		pin_clk = 1'b1;
		repeat (6) @(negedge sys_clk);
		pin_clk = 1'b0; // capture edge in falling mode
		repeat (6) @(negedge sys_clk);
		addr_valid_n = 1'b1;
		pin_addr = ~a; // released address lines show junk
		wt[0] = wait_out;
		for (int k = 1; k <= ne; k++)
		begin
			pin_clk = 1'b1;
			repeat (6) @(negedge sys_clk);
			wm = wait_out;
			pin_clk = 1'b0;
			repeat (6) @(negedge sys_clk);
			wt[k] = wait_out;
			dq[k] = dq_out;
			if (wm !== (fe ? wt[k-1] : wt[k])) glitch++;
		end
		{pin_cs_n, pin_oe_n} = 2'h3;
		pin_addr = ~pin_addr;
	endtask
endmodule

// *** test/burst_read_wait_control_tb_top.sv ***
module burst_read_wait_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   sys_clk;
	logic                   rst;
	logic                   cfg_load;
	logic [15:0]            cfg_word;
	logic [15:0]            read_setup_word;
	logic                   burst_order_bit;
	logic                   pin_clk;
	logic                   addr_valid_n;
	logic                   pin_cs_n;
	logic                   pin_oe_n;
	logic                   pin_we_n;
	logic [brw_pkg::AW-1:0] pin_addr;
	logic [brw_pkg::DW-1:0] dq_out;
	logic                   dq_oe;
	logic                   wait_out;
	logic                   wait_oe;
	logic [brw_pkg::AW-1:0] arr_addr;
	logic [brw_pkg::DW-1:0] arr_word;
	logic                   arr_valid;
	logic                   arr_ready;
	logic                   burst_active;
	logic                   saw_full;
	int                     num_errors;
	int                     check_count;

	brw_top u_brw_top (.sys_clk(sys_clk), .rst(rst), .cfg_load(cfg_load), .cfg_word(cfg_word),
		.read_setup_word(read_setup_word), .burst_order_bit(burst_order_bit), .pin_clk(pin_clk),
		.addr_valid_n(addr_valid_n), .pin_cs_n(pin_cs_n), .pin_oe_n(pin_oe_n),
		.pin_we_n(pin_we_n), .pin_addr(pin_addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.wait_out(wait_out), .wait_oe(wait_oe), .arr_addr(arr_addr), .arr_word(arr_word),
		.arr_valid(arr_valid), .arr_ready(arr_ready), .burst_active(burst_active));
	brw_host_model u_brw_host_model (.sys_clk(sys_clk), .dq_out(dq_out), .wait_out(wait_out),
		.pin_clk(pin_clk), .addr_valid_n(addr_valid_n), .pin_cs_n(pin_cs_n),
		.pin_oe_n(pin_oe_n), .pin_we_n(pin_we_n), .pin_addr(pin_addr));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// array source with random gaps; word is a scramble of its address
	always @(negedge sys_clk)
	begin
		arr_valid <= ($urandom % 4) != 0;
		arr_word <= arr_addr ^ 16'h5a5a;
		if (rst === 1'b1)
			saw_full <= 1'b0;
		else if (arr_ready === 1'b0)
			saw_full <= 1'b1;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic close_out;
		$display("Counts: %0d checks, %0d errors", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic do_reset;
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(read_setup_word, 16'hfd4f, "setup reset");
		chk(burst_order_bit, 1'b0, "order reset");
	endtask

	task automatic load(input logic [15:0] w);
		@(negedge sys_clk);
		cfg_load = 1'b1;
		cfg_word = w;
		@(negedge sys_clk);
		cfg_load = 1'b0;
		chk(read_setup_word, w & brw_pkg::SETUP_WMASK, "setup load");
		chk(burst_order_bit, 1'b0, "order bit");
	endtask

	function automatic logic [15:0] exp_addr(logic [15:0] s, int i, logic wd, logic [2:0] sz);
		logic [15:0] m;
		m = (sz == brw_pkg::SIZE_4) ? 16'h0003 : (sz == brw_pkg::SIZE_8) ? 16'h0007 : 16'h000f;
		if (wd || sz == brw_pkg::SIZE_CONT) return s + 16'(i);
		return (s & ~m) | ((s + 16'(i)) & m);
	endfunction

	// bus edge of word i: delay code, one per edge, plus the row end stall once crossed
	function automatic logic [15:0] exp_edge(logic [3:0] c, logic [15:0] s, int i, logic wd,
		logic [2:0] sz);
		int st;
		st = (s[1:0] == 2'h0) ? 0 : int'(c) - 4 + int'(s[1:0]);
		if (s[3:0] != 4'h0 && (wd || sz == brw_pkg::SIZE_CONT) && i > 15 - int'(s[3:0]))
			return 16'(int'(c) + i + st);
		return 16'(int'(c) + i);
	endfunction

	task automatic run_case(input logic [3:0] c, input logic e, input logic wd,
		input logic [2:0] sz, input logic [15:0] s, input logic p, input int n, input logic ce);
		int i;
		logic v;
		load({1'b0, c, p, 1'b0, e, 1'b0, ce, 2'h0, wd, sz});
		u_brw_host_model.burst(s, 50, !ce);
		chk(burst_active, 1'b1, "burst active");
		i = 0;
		for (int k = 2; k <= 50 && i < n; k++)
		begin
			v = e ? u_brw_host_model.wt[k-1] : u_brw_host_model.wt[k];
			if (v === ~p)
			begin
				chk(16'(k), exp_edge(c, s, i, wd, sz), "edge");
				chk(u_brw_host_model.dq[k], exp_addr(s, i, wd, sz) ^ 16'h5a5a, "data");
				i++;
			end
		end
		chk(16'(i), 16'(n), "word count");
		$display("burst code %0d start %h size %0d edge %0d done at %0t", c, s, sz, ce, $time);
	endtask

	initial
	begin
		void'($urandom(86382));
		rst = 1'b1;
		cfg_load = 1'b0;
		cfg_word = 16'h0000;
		num_errors = 0;
		check_count = 0;
		do_reset();
		// asynchronous mode: wait driven at its idle level, floated otherwise
		u_brw_host_model.ctl(1'b0, 1'b0, 1'b1);
		chk(wait_oe, 1'b1, "wait drive");
		chk(dq_oe, 1'b1, "data drive");
		chk(wait_out, 1'b0, "async wait pol1");
		load(16'hf94f);
		chk(wait_out, 1'b1, "async wait pol0");
		u_brw_host_model.ctl(1'b1, 1'b0, 1'b1);
		chk(wait_oe, 1'b0, "float cs high");
		chk(dq_oe, 1'b0, "data float cs high");
		u_brw_host_model.ctl(1'b0, 1'b1, 1'b1);
		chk(wait_oe, 1'b0, "float oe high");
		u_brw_host_model.ctl(1'b0, 1'b0, 1'b0);
		chk(wait_oe, 1'b0, "float write");
		chk(dq_oe, 1'b0, "data float write");
		u_brw_host_model.ctl(1'b1, 1'b1, 1'b1);
		$display("async and float test done at %0t", $time);
		load(16'($urandom));
		// corner bursts; delay codes kept within 5..15
		run_case(4'h5, 1'b0, 1'b1, brw_pkg::SIZE_CONT, 16'h0100, 1'b1, 18, 1'b1);
		run_case(4'hf, 1'b1, 1'b1, brw_pkg::SIZE_CONT, 16'h020e, 1'b0, 18, 1'b0);
		run_case(4'h7, 1'b0, 1'b0, brw_pkg::SIZE_4, 16'h0305, 1'b1, 4, 1'b1);
		run_case(4'h8, 1'b0, 1'b0, brw_pkg::SIZE_8, 16'h0403, 1'b1, 8, 1'b0);
		run_case(4'h6, 1'b1, 1'b1, brw_pkg::SIZE_16, 16'h0511, 1'b1, 16, 1'b1);
		run_case(4'ha, 1'b0, 1'b0, brw_pkg::SIZE_16, 16'h060c, 1'b0, 16, 1'b1);
		repeat (4)
			run_case(4'(5 + $urandom % 11), 1'($urandom), 1'b1, brw_pkg::SIZE_CONT,
				16'($urandom), 1'($urandom), 18, 1'($urandom));
		chk(saw_full, 1'b1, "fifo filled");
		chk(16'(u_brw_host_model.glitch), 16'h0000, "wait off edge");
		do_reset();
		close_out();
	end

	// watchdog: ten bursts of about 6 us each, with ample margin
	initial
	begin
		#200us;
		num_errors++;
		$display("Error at %0t: run did not finish", $time);
		close_out();
	end
endmodule
